// ===== rtl/ptcc_pkg.sv
package ptcc_pkg;
   // register indices; byte address is the index shifted by WORD_SHIFT
   localparam int WORD_SHIFT = 2;
   localparam int IDX_W = 8;
   localparam logic [7:0] IDX_PORT_DATA = 8'h07;
   localparam logic [7:0] IDX_IRQ_FLAGS = 8'h0c;
   localparam logic [7:0] IDX_COUNT = 8'h11;
   localparam logic [7:0] IDX_CONTROL = 8'h12;
   localparam logic [7:0] IDX_VALUE_LOW = 8'h15;
   localparam logic [7:0] IDX_VALUE_HIGH = 8'h16;
   localparam logic [7:0] IDX_UNIT_CONTROL = 8'h17;
   localparam logic [7:0] IDX_PORT_DIR = 8'h87;
   localparam logic [7:0] IDX_IRQ_ENABLES = 8'h8c;
   localparam logic [7:0] IDX_LIMIT = 8'h92;

   // field positions
   localparam int FLAG_W = 3;
   localparam int FLAG_MAIN_BIT = 0;
   localparam int FLAG_PERIOD_BIT = 1;
   localparam int FLAG_UNIT_BIT = 2;
   localparam int CTRL_W = 7;
   localparam int CTRL_ON_BIT = 2;
   localparam int CTRL_PRE_LSB = 0;
   localparam int CTRL_POST_LSB = 3;
   localparam int UNIT_CTRL_W = 6;
   localparam int UNIT_PIN_BIT = 2;

   // reset values
   localparam logic [7:0] RST_ZERO = 8'h00;
   localparam logic [7:0] RST_LIMIT = 8'hff;
   localparam logic [7:0] RST_DIR = 8'hff;

   // unit_mode_select encodings
   localparam logic [3:0] MODE_OFF = 4'h0;
   localparam logic [3:0] MODE_CAP_FALL = 4'h4;
   localparam logic [3:0] MODE_CAP_RISE = 4'h5;
   localparam logic [3:0] MODE_CAP_RISE4 = 4'h6;
   localparam logic [3:0] MODE_CAP_RISE16 = 4'h7;
   localparam logic [3:0] MODE_CMP_SET = 4'h8;
   localparam logic [3:0] MODE_CMP_CLEAR = 4'h9;
   localparam logic [3:0] MODE_CMP_SOFT = 4'ha;
   localparam logic [3:0] MODE_CMP_TRIGGER = 4'hb;
   localparam logic [1:0] GROUP_CAPTURE = 2'b01;
   localparam logic [1:0] GROUP_COMPARE = 2'b10;

   // instruction clock is the core clock divided by four
   localparam logic [1:0] PHASE_LAST = 2'h3;
   localparam logic [1:0] PRE_SEL_DIV1 = 2'b00;
   localparam logic [1:0] PRE_SEL_DIV4 = 2'b01;
   localparam logic [3:0] PRE_LAST_1 = 4'h0;
   localparam logic [3:0] PRE_LAST_4 = 4'h3;
   localparam logic [3:0] PRE_LAST_16 = 4'hf;
   localparam logic [3:0] EDGE_LAST_4 = 4'h3;
   localparam logic [3:0] EDGE_LAST_16 = 4'hf;

   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage

// ===== rtl/ptcc_period_capture.sv
`timescale 1ns/1ps
module ptcc_period_capture
   import ptcc_pkg::*;
#(
   parameter int AXI_ADDR_W = 10
)
(
   input wire logic clk_in,
   input wire logic reset_n_in,
   input wire logic s_axi_awvalid_in,
   input wire logic [AXI_ADDR_W-1:0] s_axi_awaddr_in,
   output logic s_axi_awready_out,
   input wire logic s_axi_wvalid_in,
   input wire logic [31:0] s_axi_wdata_in,
   input wire logic [3:0] s_axi_wstrb_in,
   output logic s_axi_wready_out,
   output logic s_axi_bvalid_out,
   output logic [1:0] s_axi_bresp_out,
   input wire logic s_axi_bready_in,
   input wire logic s_axi_arvalid_in,
   input wire logic [AXI_ADDR_W-1:0] s_axi_araddr_in,
   output logic s_axi_arready_out,
   output logic s_axi_rvalid_out,
   output logic [31:0] s_axi_rdata_out,
   output logic [1:0] s_axi_rresp_out,
   input wire logic s_axi_rready_in,
   input wire logic unit_pin_in,
   output logic unit_pin_out,
   output logic unit_pin_oe_out,
   input wire logic [15:0] main_timer_count_in,
   input wire logic main_timer_write_in,
   input wire logic main_overflow_in,
   input wire logic adc_enable_in,
   output logic period_match_out,
   output logic special_event_out,
   output logic adc_start_out
);

////////////////////////////////////////////////////////////////////////////////
   function automatic logic [IDX_W-1:0] reg_index(input logic [AXI_ADDR_W-1:0] addr);
      reg_index = addr[WORD_SHIFT +: IDX_W];
   endfunction

   function automatic logic is_mapped(input logic [IDX_W-1:0] idx);
      is_mapped = (idx == IDX_PORT_DATA) || (idx == IDX_IRQ_FLAGS) || (idx == IDX_COUNT)
         || (idx == IDX_CONTROL) || (idx == IDX_VALUE_LOW) || (idx == IDX_VALUE_HIGH)
         || (idx == IDX_UNIT_CONTROL) || (idx == IDX_PORT_DIR)
         || (idx == IDX_IRQ_ENABLES) || (idx == IDX_LIMIT);
   endfunction

   // reset is released through two flops; the rest uses rst_n
   logic [1:0] rst_sync_reg;
   logic rst_n;
   always_ff @(posedge clk_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
         rst_sync_reg <= 2'b00;
      else
         rst_sync_reg <= {rst_sync_reg[0], 1'b1};
   end
   assign rst_n = rst_sync_reg[1];

////////////////////////////////////////////////////////////////////////////////
   // write channel: address and data taken in either order, then one response
   logic have_aw_reg, have_w_reg, wstrb_low_reg, wr_fire;
   logic [IDX_W-1:0] aw_idx_reg;
   logic [7:0] wdata_reg;
   assign wr_fire = have_aw_reg && have_w_reg && !s_axi_bvalid_out;

   function automatic logic wr_hit(input logic [IDX_W-1:0] idx);
      wr_hit = wr_fire && wstrb_low_reg && (aw_idx_reg == idx);
   endfunction

   always_ff @(posedge clk_in or negedge rst_n)
   begin
      if (!rst_n)
      begin
         s_axi_awready_out <= 1'b1;
         s_axi_wready_out <= 1'b1;
         s_axi_bvalid_out <= 1'b0;
         s_axi_bresp_out <= RESP_OKAY;
         have_aw_reg <= 1'b0;
         have_w_reg <= 1'b0;
         aw_idx_reg <= RST_ZERO;
         wdata_reg <= RST_ZERO;
         wstrb_low_reg <= 1'b0;
      end
      else
      begin
         if (s_axi_awvalid_in && s_axi_awready_out)
         begin
            aw_idx_reg <= reg_index(s_axi_awaddr_in);
            have_aw_reg <= 1'b1;
            s_axi_awready_out <= 1'b0;
         end
         if (s_axi_wvalid_in && s_axi_wready_out)
         begin
            wdata_reg <= s_axi_wdata_in[7:0]; // upper lanes have no storage
            wstrb_low_reg <= s_axi_wstrb_in[0];
            have_w_reg <= 1'b1;
            s_axi_wready_out <= 1'b0;
         end
         if (wr_fire)
         begin
            have_aw_reg <= 1'b0;
            have_w_reg <= 1'b0;
            s_axi_bvalid_out <= 1'b1;
            s_axi_bresp_out <= is_mapped(aw_idx_reg) ? RESP_OKAY : RESP_SLVERR;
         end
         if (s_axi_bvalid_out && s_axi_bready_in)
         begin
            s_axi_bvalid_out <= 1'b0;
            s_axi_awready_out <= 1'b1;
            s_axi_wready_out <= 1'b1;
         end
      end
   end

////////////////////////////////////////////////////////////////////////////////
   // register state
   logic [CTRL_W-1:0] control_reg;
   logic [7:0] count_reg, limit_reg, port_data_reg, port_dir_reg;
   logic [FLAG_W-1:0] flags_reg, enables_reg;
   logic [UNIT_CTRL_W-1:0] unit_ctrl_reg;
   logic [15:0] value_reg;
   logic [3:0] mode;
   assign mode = unit_ctrl_reg[3:0];

   // read path has no side effects, so reads never disturb counters
   logic [IDX_W-1:0] ar_idx;
   logic [7:0] rd_byte;
   assign ar_idx = reg_index(s_axi_araddr_in);
   always_comb
   begin
      rd_byte = RST_ZERO;
      case (ar_idx)
         IDX_PORT_DATA: rd_byte = port_data_reg;
         IDX_IRQ_FLAGS: rd_byte = {5'h0, flags_reg};
         IDX_COUNT: rd_byte = count_reg;
         IDX_CONTROL: rd_byte = {1'b0, control_reg};
         IDX_VALUE_LOW: rd_byte = value_reg[7:0];
         IDX_VALUE_HIGH: rd_byte = value_reg[15:8];
         IDX_UNIT_CONTROL: rd_byte = {2'b00, unit_ctrl_reg};
         IDX_PORT_DIR: rd_byte = port_dir_reg;
         IDX_IRQ_ENABLES: rd_byte = {5'h0, enables_reg};
         IDX_LIMIT: rd_byte = limit_reg;
         default: rd_byte = RST_ZERO;
      endcase
   end

   always_ff @(posedge clk_in or negedge rst_n)
   begin
      if (!rst_n)
      begin
         s_axi_arready_out <= 1'b1;
         s_axi_rvalid_out <= 1'b0;
         s_axi_rdata_out <= 32'h0000_0000;
         s_axi_rresp_out <= RESP_OKAY;
      end
      else if (s_axi_arvalid_in && s_axi_arready_out)
      begin
         s_axi_arready_out <= 1'b0;
         s_axi_rvalid_out <= 1'b1;
         s_axi_rdata_out <= {24'h00_0000, rd_byte};
         s_axi_rresp_out <= is_mapped(ar_idx) ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_rvalid_out && s_axi_rready_in)
      begin
         s_axi_rvalid_out <= 1'b0;
         s_axi_arready_out <= 1'b1;
      end
   end

   // plain software registers
   always_ff @(posedge clk_in or negedge rst_n)
   begin
      if (!rst_n)
      begin
         control_reg <= CTRL_W'(RST_ZERO);
         limit_reg <= RST_LIMIT;
         enables_reg <= FLAG_W'(RST_ZERO);
         port_data_reg <= RST_ZERO;
         port_dir_reg <= RST_DIR;
         unit_ctrl_reg <= UNIT_CTRL_W'(RST_ZERO);
      end
      else
      begin
         if (wr_hit(IDX_CONTROL))
            control_reg <= wdata_reg[CTRL_W-1:0];
         if (wr_hit(IDX_LIMIT))
            limit_reg <= wdata_reg;
         if (wr_hit(IDX_IRQ_ENABLES))
            enables_reg <= wdata_reg[FLAG_W-1:0];
         if (wr_hit(IDX_PORT_DATA))
            port_data_reg <= wdata_reg;
         if (wr_hit(IDX_PORT_DIR))
            port_dir_reg <= wdata_reg;
         if (wr_hit(IDX_UNIT_CONTROL))
            unit_ctrl_reg <= wdata_reg[UNIT_CTRL_W-1:0];
      end
   end

////////////////////////////////////////////////////////////////////////////////
   // period timer: phase divider, prescaler, count, postscaler
   logic [1:0] phase_reg, pre_sel;
   logic [3:0] pre_cnt_reg, post_cnt_reg, pre_last, post_sel;
   logic tick, pre_clear, inc, period_match, post_expire, count_write;
   assign pre_sel = control_reg[CTRL_PRE_LSB +: 2];
   assign post_sel = control_reg[CTRL_POST_LSB +: 4];
   assign tick = (phase_reg == PHASE_LAST);
   // a plain net, so that properties see the sampled write strobe
   assign count_write = wr_hit(IDX_COUNT);
   assign pre_clear = count_write || wr_hit(IDX_CONTROL);
   always_comb
   begin
      unique case (pre_sel)
         PRE_SEL_DIV1: pre_last = PRE_LAST_1;
         PRE_SEL_DIV4: pre_last = PRE_LAST_4;
         default: pre_last = PRE_LAST_16;
      endcase
   end
   // a write to the count wins over the increment in the same cycle
   assign inc = tick && control_reg[CTRL_ON_BIT] && (pre_cnt_reg == pre_last)
      && !pre_clear;
   assign period_match = inc && (count_reg == limit_reg);
   assign post_expire = period_match && (post_cnt_reg == post_sel);

   always_ff @(posedge clk_in or negedge rst_n)
   begin
      if (!rst_n)
         phase_reg <= 2'b00;
      else
         phase_reg <= phase_reg + 2'b01; // instruction clock phase
   end

   always_ff @(posedge clk_in or negedge rst_n)
   begin
      if (!rst_n)
      begin
         pre_cnt_reg <= 4'h0;
         post_cnt_reg <= 4'h0;
      end
      else if (pre_clear)
      begin
         pre_cnt_reg <= 4'h0;
         post_cnt_reg <= 4'h0;
      end
      else
      begin
         if (tick && control_reg[CTRL_ON_BIT])
            pre_cnt_reg <= (pre_cnt_reg == pre_last) ? 4'h0 : pre_cnt_reg + 4'h1;
         if (period_match)
            post_cnt_reg <= post_expire ? 4'h0 : post_cnt_reg + 4'h1;
      end
   end

   always_ff @(posedge clk_in or negedge rst_n)
   begin
      if (!rst_n)
         count_reg <= RST_ZERO;
      else if (wr_hit(IDX_COUNT))
         count_reg <= wdata_reg;
      else if (inc)
         count_reg <= period_match ? RST_ZERO : count_reg + 8'h01;
   end

////////////////////////////////////////////////////////////////////////////////
   // capture: pin level seen is our own drive when the pin is an output
   logic level, prev_level_reg, rise, fall, cap_mode, cmp_mode, cap_event;
   logic [3:0] edge_cnt_reg;
   assign cap_mode = (mode[3:2] == GROUP_CAPTURE);
   assign cmp_mode = (mode[3:2] == GROUP_COMPARE);
   assign level = unit_pin_oe_out ? unit_pin_out : unit_pin_in;
   assign rise = level && !prev_level_reg;
   assign fall = !level && prev_level_reg;
   always_comb
   begin
      unique case (mode)
         MODE_CAP_FALL: cap_event = fall;
         MODE_CAP_RISE: cap_event = rise;
         MODE_CAP_RISE4: cap_event = rise && (edge_cnt_reg == EDGE_LAST_4);
         MODE_CAP_RISE16: cap_event = rise && (edge_cnt_reg == EDGE_LAST_16);
         default: cap_event = 1'b0;
      endcase
   end

   always_ff @(posedge clk_in or negedge rst_n)
   begin
      if (!rst_n)
         prev_level_reg <= 1'b0;
      else
         prev_level_reg <= level;
   end

   // prescale change without a zero write keeps the old count
   always_ff @(posedge clk_in or negedge rst_n)
   begin
      if (!rst_n)
         edge_cnt_reg <= 4'h0;
      else if (!cap_mode)
         edge_cnt_reg <= 4'h0;
      else if (cap_event)
         edge_cnt_reg <= 4'h0;
      else if (rise)
         edge_cnt_reg <= edge_cnt_reg + 4'h1;
   end

   // capture overwrites the value register and beats a coincident write
   always_ff @(posedge clk_in or negedge rst_n)
   begin
      if (!rst_n)
         value_reg <= 16'h0000;
      else if (cap_event)
         value_reg <= main_timer_count_in;
      else
      begin
         if (wr_hit(IDX_VALUE_LOW))
            value_reg[7:0] <= wdata_reg;
         if (wr_hit(IDX_VALUE_HIGH))
            value_reg[15:8] <= wdata_reg;
      end
   end

////////////////////////////////////////////////////////////////////////////////
   // compare: act once on the cycle the equality starts
   logic equal_prev_reg, cmp_hit, cmp_latch_reg, trig_hit, unit_zero_write;
   assign cmp_hit = cmp_mode && (value_reg == main_timer_count_in) && !equal_prev_reg;
   assign trig_hit = cmp_hit && (mode == MODE_CMP_TRIGGER);
   assign unit_zero_write = wr_hit(IDX_UNIT_CONTROL) && (wdata_reg == RST_ZERO);

   always_ff @(posedge clk_in or negedge rst_n)
   begin
      if (!rst_n)
         equal_prev_reg <= 1'b0;
      else
         equal_prev_reg <= cmp_mode && (value_reg == main_timer_count_in);
   end

   // soft-interrupt and trigger modes leave the latch alone
   always_ff @(posedge clk_in or negedge rst_n)
   begin
      if (!rst_n)
         cmp_latch_reg <= 1'b0;
      else if (unit_zero_write)
         cmp_latch_reg <= 1'b0;
      else if (cmp_hit && (mode == MODE_CMP_SET))
         cmp_latch_reg <= 1'b1;
      else if (cmp_hit && (mode == MODE_CMP_CLEAR))
         cmp_latch_reg <= 1'b0;
   end

   // pin drive: compare latch in compare modes, port latch otherwise
   always_ff @(posedge clk_in or negedge rst_n)
   begin
      if (!rst_n)
      begin
         unit_pin_oe_out <= 1'b0;
         unit_pin_out <= 1'b0;
      end
      else
      begin
         unit_pin_oe_out <= !port_dir_reg[UNIT_PIN_BIT];
         unit_pin_out <= cmp_mode ? cmp_latch_reg : port_data_reg[UNIT_PIN_BIT];
      end
   end

   // the special event is dropped when a main timer write lands in the same cycle; the ADC start is not
   always_ff @(posedge clk_in or negedge rst_n)
   begin
      if (!rst_n)
      begin
         period_match_out <= 1'b0;
         special_event_out <= 1'b0;
         adc_start_out <= 1'b0;
      end
      else
      begin
         period_match_out <= period_match;
         special_event_out <= trig_hit && !main_timer_write_in;
         adc_start_out <= trig_hit && adc_enable_in;
      end
   end

   // flags: hardware set wins over a software clear in the same cycle
   always_ff @(posedge clk_in or negedge rst_n)
   begin
      if (!rst_n)
         flags_reg <= FLAG_W'(RST_ZERO);
      else
      begin
         flags_reg <= (wr_hit(IDX_IRQ_FLAGS) ? wdata_reg[FLAG_W-1:0] : flags_reg)
            | {cap_event || cmp_hit, post_expire, main_overflow_in};
      end
   end

////////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!rst_n);

   sequence s_count_write;
      count_write;
   endsequence
   sequence s_prescale_idle;
      (pre_cnt_reg == 4'h0) && (post_cnt_reg == 4'h0);
   endsequence

   a_pre_clear_on_write: assert property (s_count_write |=> s_prescale_idle)
      else $error("count write did not clear prescaler and postscaler");
   a_count_held_off: assert property (!control_reg[CTRL_ON_BIT] && !count_write
      |=> $stable(count_reg))
      else $error("period count moved while timer off");
   a_count_wraps: assert property (inc && (count_reg == limit_reg) |=> count_reg == 8'h00
      && period_match_out)
      else $error("count did not wrap at limit");
   a_period_flag_set: assert property (post_expire |=> flags_reg[FLAG_PERIOD_BIT])
      else $error("postscaler expiry did not set period flag");
   a_capture_copy: assert property (cap_event |=> value_reg == $past(main_timer_count_in)
      && flags_reg[FLAG_UNIT_BIT])
      else $error("capture did not load timer value and flag");
   a_edge_held_clear: assert property (!cap_mode |=> edge_cnt_reg == 4'h0)
      else $error("edge prescaler not clear outside capture");
   // the pin falls back to the port latch, which the zero write leaves alone
   a_zero_forces_low: assert property (unit_zero_write |=> !cmp_latch_reg
      ##1 (unit_pin_out == port_data_reg[UNIT_PIN_BIT]))
      else $error("zero control write did not force latch low");
   a_soft_pin_kept: assert property (cmp_hit && (mode == MODE_CMP_SOFT) |=> $stable(cmp_latch_reg))
      else $error("soft interrupt compare changed the pin latch");
   a_trigger_pulse: assert property (trig_hit && !main_timer_write_in
      |=> special_event_out ##1 !special_event_out)
      else $error("trigger was not a single pulse");
   a_write_response: assert property (wr_fire |=> s_axi_bvalid_out)
      else $error("write response missing");
endmodule

// ===== bench/ptcc_pin_source.sv
`timescale 1ns/1ps
// external event source on the unit pin; the bench commands its level
module ptcc_pin_source
(
   input wire logic level_in,
   input wire logic pin_out_in,
   input wire logic pin_oe_in,
   output logic pin_in_out
);
   ////////////////////////////////////////////////////////////////
   // wire level: design driver wins while enabled, else the source
   assign pin_in_out = pin_oe_in ? pin_out_in : level_in;
endmodule

// ===== bench/testbench.sv
`timescale 1ns/1ps
module testbench;
   import ptcc_pkg::*;
   logic clk = 0, rst_n = 0, awv = 0, wv = 0, bv_rdy = 0, arv = 0, rv_rdy = 0;
   logic [9:0] awa = '0, ara = '0;
   logic [31:0] wd = '0, rdata;
   logic [3:0] ws = '0;
   logic [1:0] rresp;
   logic lvl = 0, adc_en = 0, pin_in, pin_out, pin_oe, match, sev, adc_go;
   logic awr, wr_rdy, bvalid, arr, rvalid;
   logic [1:0] bresp;
   logic [15:0] tmr = '0; // moves only on clk edges, a synchronous timer
   logic tmr_wr = 0, ovf = 0;
   int bad_count = 0, check_count = 0;
   ptcc_period_capture ptcc_period_capture_inst (.clk_in(clk), .reset_n_in(rst_n),
      .s_axi_awvalid_in(awv), .s_axi_awaddr_in(awa), .s_axi_awready_out(awr),
      .s_axi_wvalid_in(wv), .s_axi_wdata_in(wd), .s_axi_wstrb_in(ws),
      .s_axi_wready_out(wr_rdy), .s_axi_bvalid_out(bvalid), .s_axi_bresp_out(bresp),
      .s_axi_bready_in(bv_rdy), .s_axi_arvalid_in(arv), .s_axi_araddr_in(ara),
      .s_axi_arready_out(arr), .s_axi_rvalid_out(rvalid), .s_axi_rdata_out(rdata),
      .s_axi_rresp_out(rresp), .s_axi_rready_in(rv_rdy), .unit_pin_in(pin_in),
      .unit_pin_out(pin_out), .unit_pin_oe_out(pin_oe), .main_timer_count_in(tmr),
      .main_timer_write_in(tmr_wr), .main_overflow_in(ovf), .adc_enable_in(adc_en),
      .period_match_out(match), .special_event_out(sev), .adc_start_out(adc_go));
   ptcc_pin_source ptcc_pin_source_inst (.level_in(lvl), .pin_out_in(pin_out),
      .pin_oe_in(pin_oe), .pin_in_out(pin_in));
   ////////////////////////////////////////////////////////////////
   // 50 MHz clock
   always #10 clk = ~clk;
   task automatic close_out();
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp)
      begin
         bad_count++;
         $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   ////////////////////////////////////////////////////////////////
   // bus master: handshakes are judged at the falling edge, acted on at the rising one
   task automatic wr(input logic [7:0] idx, input logic [7:0] d);
      logic a, w, b;
      @(posedge clk);
      awv <= 1; awa <= {idx, 2'b00}; wv <= 1; wd <= {24'h00_0000, d}; ws <= 4'h1;
      bv_rdy <= 1;
      do
      begin
         @(negedge clk);
         a = awv & awr; w = wv & wr_rdy; b = bvalid;
         @(posedge clk);
         if (a) awv <= 0;
         if (w) wv <= 0;
      end while (!b);
      bv_rdy <= 0;
   endtask
   task automatic rd(input logic [7:0] idx, output logic [31:0] d, output logic [1:0] r);
      logic a, v;
      @(posedge clk);
      arv <= 1; ara <= {idx, 2'b00}; rv_rdy <= 1;
      do
      begin
         @(negedge clk);
         a = arv & arr; v = rvalid; d = rdata; r = rresp;
         @(posedge clk);
         if (a) arv <= 0;
      end while (!v);
      rv_rdy <= 0;
   endtask
   task automatic rd_cmp(input logic [7:0] idx, input logic [31:0] exp);
      logic [31:0] d;
      logic [1:0] r;
      rd(idx, d, r);
      cmp(d, exp);
   endtask
   // wait for a bench-watched pulse, return cycles spent
   task automatic wait_hi(input logic use_sev, output int n);
      n = 0;
      do
      begin
         @(negedge clk);
         n++;
      end while (!(use_sev ? sev : match) && n < 400);
   endtask
   ////////////////////////////////////////////////////////////////
   task automatic t_reset();
      logic [31:0] d;
      logic [1:0] r;
      rd_cmp(IDX_LIMIT, 32'h0000_00ff);
      rd_cmp(IDX_COUNT, 32'h0000_0000);
      rd_cmp(IDX_CONTROL, 32'h0000_0000);
      rd(8'h40, d, r);
      cmp({30'h0, r}, {30'h0, RESP_SLVERR});
      $display("reset values done");
   endtask
   task automatic t_period();
      int n;
      wr(IDX_LIMIT, 8'h03);
      wr(IDX_CONTROL, 8'h8d); // bit 7 written but must read back as zero
      rd_cmp(IDX_CONTROL, 32'h0000_000d);
      wait_hi(0, n);
      wait_hi(0, n);
      wait_hi(0, n);
      cmp(n, 64);
      rd_cmp(IDX_IRQ_FLAGS, 32'h0000_0002);
      wr(IDX_CONTROL, 8'h00);
      $display("period timer done");
   endtask
   // one pulse on the unit pin while the main timer shows t
   task automatic pulse_pin(input logic [15:0] t);
      @(posedge clk);
      tmr <= t;
      lvl <= 1;
      repeat (3) @(posedge clk);
      lvl <= 0;
      repeat (3) @(posedge clk);
   endtask
   task automatic t_capture();
      wr(IDX_IRQ_ENABLES, 8'h00);
      wr(IDX_IRQ_FLAGS, 8'h00);
      wr(IDX_UNIT_CONTROL, {4'h0, MODE_CAP_RISE});
      pulse_pin(16'h1234);
      pulse_pin(16'h5678);
      rd_cmp(IDX_VALUE_LOW, 32'h0000_0078);
      rd_cmp(IDX_VALUE_HIGH, 32'h0000_0056);
      rd_cmp(IDX_IRQ_FLAGS, 32'h0000_0004);
      wr(IDX_UNIT_CONTROL, 8'h00);
      wr(IDX_UNIT_CONTROL, {4'h0, MODE_CAP_FALL});
      pulse_pin(16'h3333);
      rd_cmp(IDX_VALUE_LOW, 32'h0000_0033);
      wr(IDX_UNIT_CONTROL, 8'h00);
      wr(IDX_UNIT_CONTROL, {4'h0, MODE_CAP_RISE4});
      repeat (3) pulse_pin(16'h4444);
      rd_cmp(IDX_VALUE_LOW, 32'h0000_0033);
      pulse_pin(16'h5555);
      rd_cmp(IDX_VALUE_LOW, 32'h0000_0055);
      wr(IDX_UNIT_CONTROL, 8'h00);
      wr(IDX_UNIT_CONTROL, {4'h0, MODE_CAP_RISE16});
      repeat (15) pulse_pin(16'h6666);
      rd_cmp(IDX_VALUE_LOW, 32'h0000_0055);
      pulse_pin(16'h7777);
      rd_cmp(IDX_VALUE_LOW, 32'h0000_0077);
      // pin as output: a port write that raises it is a capture event
      wr(IDX_PORT_DIR, 8'hfb);
      wr(IDX_UNIT_CONTROL, {4'h0, MODE_CAP_RISE});
      tmr <= 16'h0abc;
      wr(IDX_PORT_DATA, 8'h04);
      rd_cmp(IDX_VALUE_LOW, 32'h0000_00bc);
      wr(IDX_PORT_DATA, 8'h00);
      wr(IDX_PORT_DIR, 8'hff);
      wr(IDX_UNIT_CONTROL, 8'h00);
      wr(IDX_IRQ_FLAGS, 8'h00);
      wr(IDX_IRQ_ENABLES, 8'h04);
      rd_cmp(IDX_IRQ_ENABLES, 32'h0000_0004);
      $display("capture done");
   endtask
   // enter a compare mode, force a fresh match, then look at the pin
   task automatic cmp_step(input logic [3:0] m, input logic exp);
      wr(IDX_UNIT_CONTROL, {4'h0, m});
      @(posedge clk);
      tmr <= 16'h01ff;
      @(posedge clk);
      tmr <= 16'h0200;
      repeat (4) @(posedge clk);
      cmp(pin_out, exp);
   endtask
   task automatic t_compare();
      int n;
      wr(IDX_PORT_DIR, 8'hfb);
      @(negedge clk);
      cmp(pin_oe, 1);
      wr(IDX_VALUE_LOW, 8'h00);
      wr(IDX_VALUE_HIGH, 8'h02);
      cmp_step(MODE_CMP_SET, 1);
      cmp_step(MODE_CMP_CLEAR, 0);
      cmp_step(MODE_CMP_SET, 1);
      cmp_step(MODE_CMP_SOFT, 1);
      // port latch high, so a zero write must leave the pin on the port latch
      wr(IDX_PORT_DATA, 8'h04);
      wr(IDX_UNIT_CONTROL, 8'h00);
      @(negedge clk);
      cmp(pin_out, 1);
      cmp_step(MODE_CMP_SOFT, 0);
      wr(IDX_IRQ_FLAGS, 8'h00);
      wr(IDX_UNIT_CONTROL, {4'h0, MODE_CMP_TRIGGER});
      @(posedge clk);
      tmr <= 16'h01ff;
      adc_en <= 1;
      @(posedge clk);
      tmr <= 16'h0200;
      wait_hi(1, n);
      cmp(n < 5 && adc_go, 1);
      cmp(pin_out, 0);
      rd_cmp(IDX_IRQ_FLAGS, 32'h0000_0004);
      // a timer write in the match cycle wins over the special event, not over the ADC start
      @(posedge clk);
      tmr <= 16'h01ff;
      @(posedge clk);
      tmr <= 16'h0200;
      tmr_wr <= 1;
      @(posedge clk);
      tmr_wr <= 0;
      ovf <= 1;
      @(posedge clk);
      ovf <= 0;
      cmp({sev, adc_go}, 2'b01);
      rd_cmp(IDX_IRQ_FLAGS, 32'h0000_0005);
      $display("compare done");
   endtask
   ////////////////////////////////////////////////////////////////
   // main sequence and watchdog
   initial
   begin
      repeat (16) @(posedge clk);
      rst_n <= 1;
      repeat (3) @(posedge clk);
      t_reset();
      t_period();
      t_capture();
      t_compare();
      close_out();
   end
   initial
   begin
      #200000;
      bad_count++;
      close_out();
   end
endmodule
